// File: hdl/usart_pkg.sv
// usart_pkg: register map, field positions, state codes for both ends
// assumes one 10 MHz clock shared by the port and its remote partner
// Behaviour
// - two sync master modes, two async modes
// - bit rate capped at clk/5 sync, clk/4 async
// - one active-high interrupt, processor line 7
// - transmit pin always output, driver type selectable
// - sync: clock on tx, open-drain data on rx
// - modes 2 and 3 async, channels independent
// - mode 2 eight data bits, mode 3 nine
// - mode changes only while port disabled; the mode field is written as given even while enabled
// - period is round(clk/rate)-1, at least 3
// - write starts transmit; receive has own enable
// - disable resets all but rx full, ninth bit
// - ninth transmit bit written before data byte
// - buffer write clears holding-empty flag
// - idle shifter loads framed buffer, buffer empties
// - start and stop last one bit period
// - back-to-back frames, else halt, set shifter idle
// - write to full buffer ignored, collision set
// - six low status flags masked onto interrupt
// - collision cleared by status read or disable
// - rx full set on store, cleared on read
package usart_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int IRQ_LINE = 7;
   localparam logic [2:0] ADDR_CFG = 3'h0;
   localparam logic [2:0] ADDR_STAT = 3'h1;
   localparam logic [2:0] ADDR_DATA = 3'h2;
   localparam logic [2:0] ADDR_IRQ_EN = 3'h3;
   localparam logic [2:0] ADDR_PER_LO = 3'h4;
   localparam logic [2:0] ADDR_PER_HI = 3'h5;
   localparam int CFG_EN = 2;
   localparam int CFG_RX_EN = 3;
   localparam int CFG_MP = 4;
   localparam int CFG_NINTH = 7;
   localparam logic [7:0] STAT_IRQ_MASK = 8'h3F;
   localparam logic [15:0] PERIOD_RST = 16'h0003;
   localparam logic [15:0] PERIOD_MIN_SYNC = 16'h0004;
   localparam logic [15:0] PERIOD_MIN_ASYNC = 16'h0003;
   localparam logic [1:0] MODE_SYNC0 = 2'h0;
   localparam logic [1:0] MODE_ASYNC9 = 2'h3;
   localparam logic [3:0] SYNC_BITS = 4'h8;
   localparam logic [3:0] FRAME8_BITS = 4'hA;
   localparam logic [3:0] FRAME9_BITS = 4'hB;
   localparam logic DRV_PUSH_PULL = 1'b1;
   localparam int REMOTE_BAUD = 115200;
   localparam logic [15:0] REMOTE_PERIOD =
      16'((CLK_HZ + REMOTE_BAUD / 2) / REMOTE_BAUD - 1);

   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_START = 3'b010, RX_DATA = 3'b100} rx_state_t;

   // bits on the line for one async frame, start and stop included
   function automatic logic [3:0] frame_len(input logic nine);
      return nine ? FRAME9_BITS : FRAME8_BITS;
   endfunction
endpackage

// File: hdl/usart_link_if.sv
// usart_link_if: the two serial lines between the port and its partner
// assumes pull-ups on both lines; a released driver reads as high
interface usart_link_if;
   logic txd_out;
   logic txd_oe_n;
   logic dev_rxd_out;
   logic dev_rxd_oe_n;
   logic rem_rxd_out;
   logic rem_rxd_oe_n;
   logic txd_line;
   logic rxd_line;
   assign txd_line = txd_oe_n | txd_out;
   // wired-and: any enabled low driver pulls the line down
   assign rxd_line = (dev_rxd_oe_n | dev_rxd_out) & (rem_rxd_oe_n | rem_rxd_out);
   modport device (output txd_out, txd_oe_n, dev_rxd_out, dev_rxd_oe_n,
                   input txd_line, rxd_line);
   modport remote (output rem_rxd_out, rem_rxd_oe_n, input txd_line, rxd_line);
endinterface

// File: hdl/usart_device.sv
// usart_device: serial port with register port, async and sync master modes
// assumes software follows the mode, period and ninth-bit ordering limits
module usart_device
   import usart_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_pin_driver_select,
   output logic [7:0] o_rdata,
   output logic o_irq,
   usart_link_if.device lnk
);
   typedef struct packed {
      logic [1:0] mode;
      logic en;
      logic rx_en;
      logic mp;
      logic nine;
      logic [15:0] period;
      logic [7:0] irq_en;
      logic [7:0] txbuf;
      logic hold_empty;
      logic sh_idle;
      logic wcol;
      logic rx_full;
      logic ovf;
      logic serr;
      logic rx_b8;
      logic [7:0] rxbuf;
      tx_state_t tx_state;
      logic [10:0] tx_sr;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bits;
      rx_state_t rx_state;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bits;
      logic [9:0] rx_sr;
      logic rx_prev;
      logic [7:0] rdata;
      logic irq;
      logic txd_out;
      logic txd_oe_n;
      logic rxd_out;
      logic rxd_oe_n;
   } dev_state_t;

   dev_state_t s_r;
   dev_state_t s_nxt;
   logic sync_m;
   logic nine_m;
   logic load;
   logic st;
   logic st_b8;
   logic [7:0] st_data;
   logic [15:0] per;
   logic [15:0] q1;
   logic [15:0] q3;
   logic [15:0] samp_pt;
   logic [7:0] stat;

   always_comb begin
      s_nxt = s_r;
      load = 1'b0;
      st = 1'b0;
      st_b8 = 1'b0;
      st_data = '0;
      sync_m = ~s_r.mode[1];
      nine_m = (s_r.mode == MODE_ASYNC9);
      // short periods are raised to the fastest legal line rate
      per = s_r.period;
      if (sync_m && per < PERIOD_MIN_SYNC) begin
         per = PERIOD_MIN_SYNC;
      end
      if (!sync_m && per < PERIOD_MIN_ASYNC) begin
         per = PERIOD_MIN_ASYNC;
      end
      q1 = (per + 16'h1) >> 2;
      q3 = q1 + (q1 << 1);
      samp_pt = (s_r.mode == MODE_SYNC0) ? q3 : per;
      stat = {s_r.rx_b8, 1'b0, s_r.serr, s_r.ovf, s_r.rx_full, s_r.wcol, s_r.sh_idle,
              s_r.hold_empty};
      s_nxt.irq = |(stat & STAT_IRQ_MASK & s_r.irq_en);
      s_nxt.rdata = '0;
      s_nxt.rx_prev = lnk.rxd_line;

      // register reads; clear-on-read comes first so a hardware set wins
      if (i_rd) begin
         case (i_addr)
            ADDR_CFG: s_nxt.rdata = {s_r.nine, 2'h0, s_r.mp, s_r.rx_en, s_r.en, s_r.mode};
            ADDR_STAT: begin
               s_nxt.rdata = stat;
               s_nxt.wcol = 1'b0;
               s_nxt.ovf = 1'b0;
               s_nxt.serr = 1'b0;
            end
            ADDR_DATA: begin
               s_nxt.rdata = s_r.rxbuf;
               s_nxt.rx_full = 1'b0;
            end
            ADDR_IRQ_EN: s_nxt.rdata = s_r.irq_en;
            ADDR_PER_LO: s_nxt.rdata = s_r.period[7:0];
            ADDR_PER_HI: s_nxt.rdata = s_r.period[15:8];
            default: s_nxt.rdata = '0;
         endcase
      end

      if (i_wr) begin
         case (i_addr)
            ADDR_CFG: begin
               // mode is taken as written; software keeps it stable while enabled
               s_nxt.mode = i_wdata[1:0];
               s_nxt.en = i_wdata[CFG_EN];
               s_nxt.rx_en = i_wdata[CFG_RX_EN];
               s_nxt.mp = i_wdata[CFG_MP];
               if (i_wdata[CFG_NINTH] != s_r.nine) begin
                  if (s_r.hold_empty) begin
                     s_nxt.nine = i_wdata[CFG_NINTH];
                  end else begin
                     s_nxt.wcol = 1'b1;
                  end
               end
            end
            ADDR_DATA: begin
               if (s_r.hold_empty) begin
                  s_nxt.txbuf = i_wdata;
                  s_nxt.hold_empty = 1'b0;
               end else begin
                  s_nxt.wcol = 1'b1;
               end
            end
            ADDR_IRQ_EN: s_nxt.irq_en = i_wdata;
            ADDR_PER_LO: s_nxt.period[7:0] = i_wdata;
            ADDR_PER_HI: s_nxt.period[15:8] = i_wdata;
            default: ;
         endcase
      end

      // transmit shifter; in sync modes it also clocks the receive samples
      case (s_r.tx_state)
         TX_IDLE: load = s_r.en && !s_nxt.hold_empty;
         TX_SHIFT: begin
            s_nxt.tx_cnt = s_r.tx_cnt + 16'h1;
            if (sync_m && s_r.tx_cnt == samp_pt) begin
               s_nxt.rx_sr[SYNC_BITS - s_r.tx_bits] = lnk.rxd_line;
               if (s_r.tx_bits == 4'h1 && s_r.rx_en) begin
                  st = 1'b1;
                  st_data = {lnk.rxd_line, s_r.rx_sr[6:0]};
                  st_b8 = s_r.rx_b8;
               end
            end
            if (s_r.tx_cnt == per) begin
               s_nxt.tx_cnt = '0;
               s_nxt.tx_sr = {1'b1, s_r.tx_sr[10:1]};
               s_nxt.tx_bits = s_r.tx_bits - 4'h1;
               if (s_r.tx_bits == 4'h1) begin
                  if (!s_nxt.hold_empty) begin
                     load = 1'b1;
                  end else begin
                     s_nxt.tx_state = TX_IDLE;
                     s_nxt.sh_idle = 1'b1;
                  end
               end
            end
         end
         default: s_nxt.tx_state = TX_IDLE;
      endcase

      if (load) begin
         s_nxt.tx_state = TX_SHIFT;
         s_nxt.tx_cnt = '0;
         s_nxt.sh_idle = 1'b0;
         s_nxt.hold_empty = 1'b1;
         if (sync_m) begin
            s_nxt.tx_sr = {3'h7, s_nxt.txbuf};
            s_nxt.tx_bits = SYNC_BITS;
         end else begin
            // stop or pad, ninth or stop, data, start
            s_nxt.tx_sr = {1'b1, nine_m ? s_nxt.nine : 1'b1, s_nxt.txbuf, 1'b0};
            s_nxt.tx_bits = frame_len(nine_m);
         end
      end

      // async receiver runs apart from the transmitter
      if (!sync_m && s_r.rx_en) begin
         case (s_r.rx_state)
            RX_IDLE: begin
               if (s_r.rx_prev && !lnk.rxd_line) begin
                  s_nxt.rx_state = RX_START;
                  s_nxt.rx_cnt = '0;
               end
            end
            RX_START: begin
               s_nxt.rx_cnt = s_r.rx_cnt + 16'h1;
               if (s_r.rx_cnt == (per >> 1)) begin
                  s_nxt.rx_cnt = '0;
                  s_nxt.rx_bits = '0;
                  if (lnk.rxd_line) begin
                     s_nxt.serr = 1'b1;
                     s_nxt.rx_state = RX_IDLE;
                  end else begin
                     s_nxt.rx_state = RX_DATA;
                  end
               end
            end
            RX_DATA: begin
               s_nxt.rx_cnt = s_r.rx_cnt + 16'h1;
               if (s_r.rx_cnt == per) begin
                  s_nxt.rx_cnt = '0;
                  s_nxt.rx_sr[s_r.rx_bits] = lnk.rxd_line;
                  s_nxt.rx_bits = s_r.rx_bits + 4'h1;
                  if (s_r.rx_bits == frame_len(nine_m) - 4'h2) begin
                     s_nxt.rx_state = RX_IDLE;
                     st_b8 = nine_m ? s_r.rx_sr[8] : lnk.rxd_line;
                     st = !s_r.mp || st_b8;
                     st_data = s_r.rx_sr[7:0];
                  end
               end
            end
            default: s_nxt.rx_state = RX_IDLE;
         endcase
      end

      if (st) begin
         if (s_nxt.rx_full) begin
            s_nxt.ovf = 1'b1;
         end else begin
            s_nxt.rxbuf = st_data;
            s_nxt.rx_b8 = st_b8;
            s_nxt.rx_full = 1'b1;
         end
      end

      // rx full and the received ninth bit survive, so a stored byte can still be read
      if (!s_r.en) begin
         s_nxt.tx_state = TX_IDLE;
         s_nxt.rx_state = RX_IDLE;
         s_nxt.tx_cnt = '0;
         s_nxt.rx_cnt = '0;
         s_nxt.hold_empty = 1'b1;
         s_nxt.sh_idle = 1'b1;
         s_nxt.wcol = 1'b0;
         s_nxt.ovf = 1'b0;
         s_nxt.serr = 1'b0;
      end

      s_nxt.txd_out = 1'b1;
      s_nxt.rxd_out = 1'b1;
      s_nxt.rxd_oe_n = 1'b1;
      if (s_nxt.tx_state == TX_SHIFT) begin
         if (sync_m) begin
            s_nxt.txd_out = !(s_nxt.tx_cnt >= q1 && s_nxt.tx_cnt < q3);
            s_nxt.rxd_out = s_nxt.tx_sr[0];
            s_nxt.rxd_oe_n = s_nxt.tx_sr[0];
         end else begin
            s_nxt.txd_out = s_nxt.tx_sr[0];
         end
      end
      s_nxt.txd_oe_n = (i_pin_driver_select == DRV_PUSH_PULL) ? 1'b0 : s_nxt.txd_out;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
         s_r.period <= PERIOD_RST;
         s_r.hold_empty <= 1'b1;
         s_r.sh_idle <= 1'b1;
         s_r.tx_state <= TX_IDLE;
         s_r.rx_state <= RX_IDLE;
         s_r.rx_prev <= 1'b1;
         s_r.txd_out <= 1'b1;
         s_r.txd_oe_n <= 1'b1;
         s_r.rxd_out <= 1'b1;
         s_r.rxd_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_rdata = s_r.rdata;
   assign o_irq = s_r.irq;
   assign lnk.txd_out = s_r.txd_out;
   assign lnk.txd_oe_n = s_r.txd_oe_n;
   assign lnk.dev_rxd_out = s_r.rxd_out;
   assign lnk.dev_rxd_oe_n = s_r.rxd_oe_n;
endmodule

// File: hdl/usart_remote.sv
// usart_remote: async partner on the far end of the two lines
// assumes the same bit period as the port; sends on rxd, listens on txd
module usart_remote
   import usart_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [15:0] i_period,
   input wire logic i_nine_bits,
   input wire logic [8:0] i_tx_data,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   output logic [8:0] o_rx_data,
   output logic o_rx_valid,
   output logic o_rx_frame_err,
   usart_link_if.remote lnk
);
   typedef struct packed {
      tx_state_t tx_state;
      logic [10:0] tx_sr;
      logic [15:0] tx_cnt;
      logic [3:0] tx_bits;
      logic tx_ready;
      rx_state_t rx_state;
      logic [15:0] rx_cnt;
      logic [3:0] rx_bits;
      logic [9:0] rx_sr;
      logic rx_prev;
      logic [8:0] rx_data;
      logic rx_valid;
      logic frame_err;
      logic line_out;
   } rem_state_t;

   rem_state_t s_r;
   rem_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.rx_valid = 1'b0;
      s_nxt.rx_prev = lnk.txd_line;
      case (s_r.tx_state)
         TX_IDLE: begin
            if (i_tx_valid && s_r.tx_ready) begin
               s_nxt.tx_state = TX_SHIFT;
               s_nxt.tx_ready = 1'b0;
               s_nxt.tx_cnt = '0;
               s_nxt.tx_sr = {1'b1, i_nine_bits ? i_tx_data[8] : 1'b1, i_tx_data[7:0], 1'b0};
               s_nxt.tx_bits = frame_len(i_nine_bits);
            end
         end
         TX_SHIFT: begin
            s_nxt.tx_cnt = s_r.tx_cnt + 16'h1;
            if (s_r.tx_cnt == i_period) begin
               s_nxt.tx_cnt = '0;
               s_nxt.tx_sr = {1'b1, s_r.tx_sr[10:1]};
               s_nxt.tx_bits = s_r.tx_bits - 4'h1;
               if (s_r.tx_bits == 4'h1) begin
                  s_nxt.tx_state = TX_IDLE;
                  s_nxt.tx_ready = 1'b1;
               end
            end
         end
         default: s_nxt.tx_state = TX_IDLE;
      endcase
      s_nxt.line_out = (s_nxt.tx_state == TX_SHIFT) ? s_nxt.tx_sr[0] : 1'b1;

      case (s_r.rx_state)
         RX_IDLE: begin
            if (s_r.rx_prev && !lnk.txd_line) begin
               s_nxt.rx_state = RX_START;
               s_nxt.rx_cnt = '0;
            end
         end
         RX_START: begin
            s_nxt.rx_cnt = s_r.rx_cnt + 16'h1;
            if (s_r.rx_cnt == (i_period >> 1)) begin
               s_nxt.rx_cnt = '0;
               s_nxt.rx_bits = '0;
               s_nxt.rx_state = lnk.txd_line ? RX_IDLE : RX_DATA;
            end
         end
         RX_DATA: begin
            s_nxt.rx_cnt = s_r.rx_cnt + 16'h1;
            if (s_r.rx_cnt == i_period) begin
               s_nxt.rx_cnt = '0;
               s_nxt.rx_sr[s_r.rx_bits] = lnk.txd_line;
               s_nxt.rx_bits = s_r.rx_bits + 4'h1;
               if (s_r.rx_bits == frame_len(i_nine_bits) - 4'h2) begin
                  s_nxt.rx_state = RX_IDLE;
                  s_nxt.rx_data = {i_nine_bits & s_r.rx_sr[8], s_r.rx_sr[7:0]};
                  s_nxt.frame_err = !lnk.txd_line;
                  s_nxt.rx_valid = 1'b1;
               end
            end
         end
         default: s_nxt.rx_state = RX_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
         s_r.tx_state <= TX_IDLE;
         s_r.rx_state <= RX_IDLE;
         s_r.tx_ready <= 1'b1;
         s_r.rx_prev <= 1'b1;
         s_r.line_out <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // drives low only, so it can share the line with the port's open drain
   assign lnk.rem_rxd_out = s_r.line_out;
   assign lnk.rem_rxd_oe_n = s_r.line_out;
   assign o_tx_ready = s_r.tx_ready;
   assign o_rx_data = s_r.rx_data;
   assign o_rx_valid = s_r.rx_valid;
   assign o_rx_frame_err = s_r.frame_err;
endmodule

// File: test/usart_link_assertions.sv
// usart_link_checker: wire-level checks on the two serial lines of the link
// assumes async modes only and a bit period of 8 clocks on both ends
module usart_link_checker (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic dev_rxd_oe_n,
   input wire logic txd_line,
   input wire logic rxd_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // longest legal low run: start plus nine zero data bits, 8 clocks each
   localparam int MAX_LOW = 80;
   logic [7:0] tx_low_r;
   logic [7:0] tx_low_nxt;
   logic [7:0] rx_low_r;
   logic [7:0] rx_low_nxt;

   always_comb begin
      tx_low_nxt = txd_line ? 8'h00 : tx_low_r + 8'h01;
      rx_low_nxt = rxd_line ? 8'h00 : rx_low_r + 8'h01;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx_low_r <= 8'h00;
         rx_low_r <= 8'h00;
      end else begin
         tx_low_r <= tx_low_nxt;
         rx_low_r <= rx_low_nxt;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_idle_after_reset: assert property ($rose(i_rst_n) |-> txd_line && rxd_line)
      else $error("line not idle high after reset");
   a_tx_start_len: assert property ($fell(txd_line) |=> !txd_line [*7])
      else $error("transmit start bit too short");
   a_tx_bit_hold: assert property ($changed(txd_line) |=> $stable(txd_line) [*7])
      else $error("transmit bit shorter than period");
   a_tx_low_bound: assert property (tx_low_r <= 8'(MAX_LOW))
      else $error("transmit frame lacks stop bit");
   a_rx_start_len: assert property ($fell(rxd_line) |=> !rxd_line [*7])
      else $error("receive start bit too short");
   a_rx_bit_hold: assert property ($changed(rxd_line) |=> $stable(rxd_line) [*7])
      else $error("receive bit shorter than period");
   a_rx_low_bound: assert property (rx_low_r <= 8'(MAX_LOW))
      else $error("receive frame lacks stop bit");
   a_dev_rxd_quiet: assert property (dev_rxd_oe_n)
      else $error("port drives receive line in async mode");
endmodule

// File: test/tb_usart_async_transmit_core.sv
// tb_usart_async_transmit_core: port and remote partner joined on one link
// assumes both ends share a bit period of 8 clocks; async modes only
module tb_usart_async_transmit_core;
   import usart_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] PER = 16'h0007;
   localparam int BIT = 8;
   logic i_clk, i_rst_n, wr, rd, drv_sel, irq;
   logic r_nine, r_valid, r_ready, r_rx_valid, r_ferr;
   logic rst_q, drv_q;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, v;
   logic [8:0] r_data, r_rx_data;
   int seed = 32'h2CB5;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [8:0] rxq[$];
   int rxt[$];

   usart_link_if lnk ();
   usart_device usart_device_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_pin_driver_select(drv_sel), .o_rdata(rdata),
      .o_irq(irq), .lnk(lnk));
   usart_remote usart_remote_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_period(PER),
      .i_nine_bits(r_nine), .i_tx_data(r_data), .i_tx_valid(r_valid), .o_tx_ready(r_ready),
      .o_rx_data(r_rx_data), .o_rx_valid(r_rx_valid), .o_rx_frame_err(r_ferr), .lnk(lnk));
   usart_link_checker usart_link_checker_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .dev_rxd_oe_n(lnk.dev_rxd_oe_n), .txd_line(lnk.txd_line), .rxd_line(lnk.rxd_line));

   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // whole run is several hundred cycles
   always @(posedge i_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         wrap_up();
      end
   end

   // remote output pulse caught mid-cycle, away from the edge
   always @(negedge i_clk) begin
      if (r_rx_valid === 1'b1) begin
         rxq.push_back(r_rx_data);
         rxt.push_back(cyc);
         chk(r_ferr, 1'b0);
      end
      // driver type follows the select one cycle late, so skip the cycle it moves
      if (rst_q === 1'b1 && drv_q === drv_sel) begin
         chk(lnk.txd_oe_n, drv_sel ? 1'b0 : lnk.txd_out);
      end
      rst_q = i_rst_n;
      drv_q = drv_sel;
   end

   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks=%0d errors=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge i_clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge i_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // polling also clears the collision flag, so use it only where that is fine
   task automatic wait_bit(input int b);
      v = 8'h00;
      for (int i = 0; i < 400 && v[b] !== 1'b1; i++) rd_reg(ADDR_STAT, v);
   endtask

   task automatic send(input logic [8:0] d, input logic [7:0] cfg);
      wait_bit(0);
      wr_reg(ADDR_CFG, {d[8], cfg[6:0]});
      wr_reg(ADDR_DATA, d[7:0]);
   endtask

   // valid stands until the partner is seen ready at a rising edge
   task automatic rsend(input logic [8:0] d);
      @(posedge i_clk);
      r_data <= d;
      r_valid <= 1'b1;
      @(posedge i_clk);
      while (r_ready !== 1'b1) @(posedge i_clk);
      r_valid <= 1'b0;
   endtask

   function automatic logic [7:0] stat(input logic he, si, wc, rf, r9);
      return {r9, 3'b000, rf, wc, si, he};
   endfunction

   initial begin
      logic [8:0] d[4];
      logic [8:0] rv;
      wr = 1'b0;
      rd = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      drv_sel = 1'b1;
      r_nine = 1'b0;
      r_valid = 1'b0;
      r_data = 9'h000;
      i_rst_n = 1'b0;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd_reg(ADDR_STAT, v);
      chk(v, stat(1, 1, 0, 0, 0));
      rd_reg(3'h6, v);
      chk(v, 8'h00);
      wr_reg(ADDR_PER_LO, PER[7:0]);
      wr_reg(ADDR_PER_HI, PER[15:8]);
      wr_reg(ADDR_CFG, 8'h0E);
      wr_reg(ADDR_IRQ_EN, 8'h04);
      // second byte waits in the buffer, third one must bounce
      wr_reg(ADDR_DATA, 8'hA5);
      wr_reg(ADDR_DATA, 8'h00);
      wr_reg(ADDR_DATA, 8'hFF);
      repeat (2) @(negedge i_clk);
      chk(irq, 1'b1);
      rd_reg(ADDR_STAT, v);
      chk(v, stat(0, 0, 1, 0, 0));
      repeat (2) @(negedge i_clk);
      chk(irq, 1'b0);
      rd_reg(ADDR_STAT, v);
      chk(v, stat(0, 0, 0, 0, 0));
      wait_bit(1);
      chk(v, stat(1, 1, 0, 0, 0));
      chk(9'(rxt[1] - rxt[0]), 9'(10 * BIT));
      chk(rxq.pop_front(), 9'h0A5);
      chk(rxq.pop_front(), 9'h000);
      wr_reg(ADDR_IRQ_EN, 8'h02);
      repeat (2) @(negedge i_clk);
      chk(irq, 1'b1);
      wr_reg(ADDR_IRQ_EN, 8'h00);
      repeat (2) @(negedge i_clk);
      chk(irq, 1'b0);
      // nine-bit traffic both ways at once, open-drain transmit driver
      wr_reg(ADDR_CFG, 8'h00);
      drv_sel <= 1'b0;
      r_nine <= 1'b1;
      wr_reg(ADDR_CFG, 8'h0F);
      rxq.delete();
      rv = 9'($random(seed));
      fork
         rsend(rv);
      join_none
      d[0] = 9'h100;
      for (int i = 1; i < 4; i++) d[i] = 9'($random(seed));
      for (int i = 0; i < 4; i++) send(d[i], 8'h0F);
      wr_reg(ADDR_CFG, {~d[3][8], 7'h0F});
      rd_reg(ADDR_STAT, v);
      chk(v[2], 1'b1);
      for (int i = 0; i < 2000 && rxq.size() < 4; i++) @(negedge i_clk);
      repeat (2 * BIT) @(negedge i_clk);
      for (int i = 0; i < 4; i++) chk(rxq.pop_front(), d[i]);
      wr_reg(ADDR_CFG, 8'h00);
      rd_reg(ADDR_STAT, v);
      chk(v, stat(1, 1, 0, 1, rv[8]));
      rd_reg(ADDR_DATA, v);
      chk(v, rv[7:0]);
      rd_reg(ADDR_STAT, v);
      chk(v, stat(1, 1, 0, 0, rv[8]));
      // multiprocessor filter: ninth bit 0 dropped, ninth bit 1 stored
      wr_reg(ADDR_CFG, 8'h1F);
      rsend(9'h05A);
      rsend(9'h1C3);
      repeat (14 * BIT) @(negedge i_clk);
      rd_reg(ADDR_STAT, v);
      chk(v, stat(1, 1, 0, 1, 1'b1));
      rd_reg(ADDR_DATA, v);
      chk(v, 8'hC3);
      wrap_up();
   end
endmodule
